// ===== verilog/io_trap_consts.vh
// Purpose: Offsets, field positions, reset values and widths for the I/O trap monitor block
// Assumes: Configuration offsets are byte addresses in the function's config space
// Notes:   Definitions only
`ifndef IO_TRAP_CONSTS_VH
`define IO_TRAP_CONSTS_VH

// Configuration space byte offsets
`define CFG_TRAP_FORWARD_ENABLE 8'hC0
`define CFG_MONITOR4_BASE_LO    8'hC4
`define CFG_MONITOR4_BASE_HI    8'hC5
`define CFG_MONITOR5_BASE_LO    8'hC6
`define CFG_MONITOR5_BASE_HI    8'hC7
`define CFG_MONITOR6_BASE_LO    8'hC8
`define CFG_MONITOR6_BASE_HI    8'hC9
`define CFG_MONITOR7_BASE_LO    8'hCA
`define CFG_MONITOR7_BASE_HI    8'hCB
`define CFG_TRAP_MASKS_LO       8'hCC
`define CFG_TRAP_MASKS_HI       8'hCD

// Fixed I/O ports
`define IO_APM_COMMAND_PORT     16'h00B2
`define IO_APM_SCRATCH_PORT     16'h00B3

// Offsets from the power management I/O base
`define PM_MON_ENABLE_OFS       16'h0040
`define PM_MON_STATUS_OFS       16'h0041

// Field positions
`define FWD_EN_LSB              4
`define FWD_EN_MSB              7
`define MASK_FIELD_W            4

// Reset values
`define RST_BYTE                8'h00
`define RST_WORD                16'h0000
`define RST_NIBBLE              4'h0

`endif

// ===== verilog/trap_window_match.v
// Purpose: Address match of one I/O monitor against its base and low mask
// Assumes: Address and base are full 16-bit I/O addresses
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/100ps
module trap_window_match #(
  parameter ADDR_W = 16,
  parameter MASK_W = 4
) (
  input  wire [ADDR_W-1:0] io_addr_i,
  input  wire [ADDR_W-1:0] monitor_base_address_i,
  input  wire [MASK_W-1:0] monitor_low_mask_i,
  output wire              hit_o
);

  wire [ADDR_W-1:0] care;

  // Masked low bits drop out of the compare
  assign care  = ~{{(ADDR_W-MASK_W){1'b0}}, monitor_low_mask_i};
  assign hit_o = ((io_addr_i ^ monitor_base_address_i) & care) == {ADDR_W{1'b0}};

endmodule // trap_window_match

// ===== verilog/io_trap_monitor_apm_smi.v
// Purpose: I/O trap monitors 4..7, LPC forward gating and APM ports with interrupt request
// Assumes: Config and I/O requests are one-cycle strobes synchronous to core_clk_i
// Notes:   Answers and trap results appear one cycle after the strobe
//          Match status at base plus 41h is sticky; a new hit wins over a clear
`timescale 1ns/100ps
`include "io_trap_consts.vh"
module io_trap_monitor_apm_smi #(
  parameter MON_N = 4
) (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  // Configuration space byte access
  input  wire        cfg_wr_i,
  input  wire        cfg_rd_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire [7:0]  cfg_wdata_i,
  output reg  [7:0]  cfg_rdata_o,
  output reg         cfg_rvalid_o,
  // Host I/O cycle
  input  wire        io_valid_i,
  input  wire        io_write_i,
  input  wire [15:0] io_addr_i,
  input  wire [7:0]  io_wdata_i,
  output reg  [7:0]  io_rdata_o,
  output reg         io_claim_o,
  // Loose control bits held elsewhere
  input  wire [15:0] power_mgmt_io_base_i,
  input  wire        apm_port_decode_enable_i,
  input  wire        apm_command_irq_enable_i,
  // Results toward the cycle decoder, LPC bridge and interrupt logic
  output reg  [3:0]  trap_hit_o,
  output reg         forward_lpc_o,
  output reg         system_management_irq_o,
  output reg  [7:0]  apm_command_port_o
);

  reg  [3:0]  trap_forward_enable;
  reg  [15:0] monitor_trap_base_reg [0:3];
  reg  [15:0] trap_range_masks;
  reg  [7:0]  apm_command_port;
  reg  [7:0]  apm_scratch_port;
  reg  [3:0]  monitor_interrupt_enable;
  reg  [3:0]  monitor_trap_status;

  wire [3:0]  hit;
  wire [3:0]  cycle_hit;
  wire        apm_cmd_sel;
  wire        apm_scr_sel;
  wire        pm_en_sel;
  wire        pm_sts_sel;
  wire        apm_cmd_wr;
  wire        apm_scr_wr;
  wire        pm_en_wr;
  wire        pm_sts_wr;
  wire        io_rd;
  wire [15:0] pm_en_addr;
  wire [15:0] pm_sts_addr;
  integer     wr_k;
  integer     rd_k;

  // Config offset of byte b of monitor m's base word
  function [7:0] base_ofs;
    input integer m;
    input integer b;
    reg   [8:0]   ofs_sum;
    begin
      ofs_sum  = {1'b0, `CFG_MONITOR4_BASE_LO} + {2'b00, m[5:0], 1'b0} + {8'h00, b[0]};
      base_ofs = ofs_sum[7:0];
    end
  endfunction

  // Port address above the power management base; wraps at the top of I/O space
  function [15:0] pm_port_addr;
    input [15:0] base;
    input [15:0] ofs;
    reg   [16:0] sum;
    begin
      sum          = {1'b0, base} + {1'b0, ofs};
      pm_port_addr = sum[15:0];
    end
  endfunction

  // Write strobe of the presented I/O cycle toward one port
  function io_write_to;
    input valid;
    input write;
    input sel;
    begin
      io_write_to = valid && write && sel;
    end
  endfunction

  // Four-bit field in the upper nibble; the reserved lower nibble reads zero
  function [7:0] upper_nibble_byte;
    input [3:0] field;
    begin
      upper_nibble_byte = {field, 4'h0};
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < MON_N; g = g + 1) begin : g_mon
      trap_window_match #(
        .ADDR_W (16),
        .MASK_W (`MASK_FIELD_W)
      ) u_match (
        .io_addr_i              (io_addr_i),
        .monitor_base_address_i (monitor_trap_base_reg[g]),
        .monitor_low_mask_i     (trap_range_masks[g*4+3:g*4]),
        .hit_o                  (hit[g])
      );
    end
  endgenerate

  assign pm_en_addr  = pm_port_addr(power_mgmt_io_base_i, `PM_MON_ENABLE_OFS);
  assign pm_sts_addr = pm_port_addr(power_mgmt_io_base_i, `PM_MON_STATUS_OFS);
  assign apm_cmd_sel = apm_port_decode_enable_i && (io_addr_i == `IO_APM_COMMAND_PORT);
  assign apm_scr_sel = apm_port_decode_enable_i && (io_addr_i == `IO_APM_SCRATCH_PORT);
  assign pm_en_sel   = (io_addr_i == pm_en_addr);
  assign pm_sts_sel  = (io_addr_i == pm_sts_addr);
  assign apm_cmd_wr  = io_write_to(io_valid_i, io_write_i, apm_cmd_sel);
  assign apm_scr_wr  = io_write_to(io_valid_i, io_write_i, apm_scr_sel);
  assign pm_en_wr    = io_write_to(io_valid_i, io_write_i, pm_en_sel);
  assign pm_sts_wr   = io_write_to(io_valid_i, io_write_i, pm_sts_sel);
  assign io_rd       = io_valid_i && !io_write_i;
  // Match results count only while an I/O cycle is presented
  assign cycle_hit   = io_valid_i ? hit : 4'h0;

  // Forward enables; the reserved low nibble is not stored
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trap_forward_enable <= `RST_NIBBLE;
    end else if (ce_i && cfg_wr_i && (cfg_addr_i == `CFG_TRAP_FORWARD_ENABLE)) begin
      trap_forward_enable <= cfg_wdata_i[`FWD_EN_MSB:`FWD_EN_LSB];
    end
  end

  // Shared mask word, one nibble per monitor
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trap_range_masks <= `RST_WORD;
    end else if (ce_i && cfg_wr_i) begin
      if (cfg_addr_i == `CFG_TRAP_MASKS_LO) begin
        trap_range_masks[7:0] <= cfg_wdata_i;
      end
      if (cfg_addr_i == `CFG_TRAP_MASKS_HI) begin
        trap_range_masks[15:8] <= cfg_wdata_i;
      end
    end
  end

  // Base words, written a byte at a time
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (wr_k = 0; wr_k < 4; wr_k = wr_k + 1) begin
        monitor_trap_base_reg[wr_k] <= `RST_WORD;
      end
    end else if (ce_i && cfg_wr_i) begin
      for (wr_k = 0; wr_k < 4; wr_k = wr_k + 1) begin
        if (cfg_addr_i == base_ofs(wr_k, 0)) begin
          monitor_trap_base_reg[wr_k][7:0] <= cfg_wdata_i;
        end
        if (cfg_addr_i == base_ofs(wr_k, 1)) begin
          monitor_trap_base_reg[wr_k][15:8] <= cfg_wdata_i;
        end
      end
    end
  end

  // Configuration read path
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_rdata_o  <= `RST_BYTE;
      cfg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        // Unmapped offsets read zero
        cfg_rdata_o <= `RST_BYTE;
        if (cfg_addr_i == `CFG_TRAP_FORWARD_ENABLE) begin
          cfg_rdata_o <= upper_nibble_byte(trap_forward_enable);
        end
        if (cfg_addr_i == `CFG_TRAP_MASKS_LO) begin
          cfg_rdata_o <= trap_range_masks[7:0];
        end
        if (cfg_addr_i == `CFG_TRAP_MASKS_HI) begin
          cfg_rdata_o <= trap_range_masks[15:8];
        end
        for (rd_k = 0; rd_k < 4; rd_k = rd_k + 1) begin
          if (cfg_addr_i == base_ofs(rd_k, 0)) begin
            cfg_rdata_o <= monitor_trap_base_reg[rd_k][7:0];
          end
          if (cfg_addr_i == base_ofs(rd_k, 1)) begin
            cfg_rdata_o <= monitor_trap_base_reg[rd_k][15:8];
          end
        end
      end
    end
  end

  // Command byte; stored even while its interrupt is disabled
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      apm_command_port <= `RST_BYTE;
    end else if (ce_i && apm_cmd_wr) begin
      apm_command_port <= io_wdata_i;
    end
  end

  // Scratch byte; only a host write or reset touches it
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      apm_scratch_port <= `RST_BYTE;
    end else if (ce_i && apm_scr_wr) begin
      apm_scratch_port <= io_wdata_i;
    end
  end

  // Monitor interrupt enables in the upper nibble at base plus 40h
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      monitor_interrupt_enable <= `RST_NIBBLE;
    end else if (ce_i && pm_en_wr) begin
      monitor_interrupt_enable <= io_wdata_i[7:4];
    end
  end

  // Sticky match status; write one clears, a new hit in the same cycle wins
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      monitor_trap_status <= `RST_NIBBLE;
    end else if (ce_i) begin
      if (pm_sts_wr) begin
        monitor_trap_status <= (monitor_trap_status & ~io_wdata_i[7:4])
                               | cycle_hit;
      end else begin
        monitor_trap_status <= monitor_trap_status | cycle_hit;
      end
    end
  end

  // Per-cycle results toward the decoder, bridge and interrupt logic
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_claim_o              <= 1'b0;
      trap_hit_o              <= 4'h0;
      forward_lpc_o           <= 1'b0;
      system_management_irq_o <= 1'b0;
      apm_command_port_o      <= `RST_BYTE;
    end else if (ce_i) begin
      apm_command_port_o <= apm_command_port;
      io_claim_o         <= io_valid_i && (apm_cmd_sel || apm_scr_sel || pm_en_sel || pm_sts_sel);
      trap_hit_o         <= cycle_hit;
      // Gated only by match and forward enable; the bridge applies it to LPC targets
      forward_lpc_o      <= |(cycle_hit & trap_forward_enable);
      // No claim input feeds this, so internal targets complete untouched
      system_management_irq_o <= |(cycle_hit & monitor_interrupt_enable)
                                 || (apm_cmd_wr && apm_command_irq_enable_i);
    end
  end

  // I/O read data; zero unless a read of a claimed port
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= `RST_BYTE;
    end else if (ce_i) begin
      io_rdata_o <= `RST_BYTE;
      if (io_rd) begin
        if (apm_cmd_sel) begin
          io_rdata_o <= apm_command_port;
        end else if (apm_scr_sel) begin
          io_rdata_o <= apm_scratch_port;
        end else if (pm_en_sel) begin
          io_rdata_o <= upper_nibble_byte(monitor_interrupt_enable);
        end else if (pm_sts_sel) begin
          io_rdata_o <= upper_nibble_byte(monitor_trap_status);
        end
      end
    end
  end

endmodule // io_trap_monitor_apm_smi

// ===== dv/io_trap_properties.sv
// Purpose: Port-level timing checks of the trap monitor
// Assumes: ce_i stays high; one I/O cycle per strobe
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module io_trap_properties #(
  parameter MON_N = 4
) (
  input wire        core_clk_i,
  input wire        resetn_i,
  input wire        ce_i,
  input wire        cfg_rd_i,
  input wire [7:0]  cfg_addr_i,
  input wire [7:0]  cfg_rdata_o,
  input wire        cfg_rvalid_o,
  input wire        io_valid_i,
  input wire        io_write_i,
  input wire [15:0] io_addr_i,
  input wire [7:0]  io_wdata_i,
  input wire        io_claim_o,
  input wire [15:0] power_mgmt_io_base_i,
  input wire        apm_port_decode_enable_i,
  input wire        apm_command_irq_enable_i,
  input wire [3:0]  trap_hit_o,
  input wire        forward_lpc_o,
  input wire        system_management_irq_o,
  input wire [7:0]  apm_command_port_o
);
  wire b2_wr = io_valid_i && io_write_i && io_addr_i == 16'h00B2 && apm_port_decode_enable_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_RD_ANSWER: assert property (ce_i && cfg_rd_i |=> cfg_rvalid_o)
    else $error("config read gave no answer");
  AST_RD_QUIET: assert property (ce_i && !cfg_rd_i |=> !cfg_rvalid_o)
    else $error("config read answer without a read");
  AST_FWD_LOW_ZERO: assert property (cfg_rd_i && cfg_addr_i == 8'hC0 |=> cfg_rdata_o[3:0] == 4'h0)
    else $error("forward enable low nibble not zero");
  AST_QUIET_NO_CYCLE: assert property (!io_valid_i |=> trap_hit_o == 4'h0 && !system_management_irq_o)
    else $error("trap result without an I/O cycle");
  AST_FWD_NEEDS_HIT: assert property (forward_lpc_o |-> trap_hit_o != 4'h0)
    else $error("forward without address match");
  AST_APM_IRQ: assert property (b2_wr && apm_command_irq_enable_i |=> system_management_irq_o)
    else $error("command write gave no interrupt");
  AST_APM_STORE: assert property (b2_wr |=> io_claim_o ##1 apm_command_port_o == $past(io_wdata_i, 2))
    else $error("command byte not stored");
  AST_APM_UNDECODED: assert property (io_valid_i && io_addr_i[15:1] == 15'h0059 &&
    !apm_port_decode_enable_i && power_mgmt_io_base_i[15:8] != 8'h00 |=> !io_claim_o)
    else $error("APM port claimed while decode off");
  AST_IRQ_CAUSE: assert property ($rose(system_management_irq_o) |-> $past(io_valid_i))
    else $error("interrupt without an I/O cycle");
  C_TRAP: cover property (trap_hit_o[0] && system_management_irq_o);
  C_FWD: cover property (forward_lpc_o);
  C_APM: cover property (b2_wr ##1 io_claim_o);
endmodule // io_trap_properties

// ===== dv/host_io_model.sv
// Purpose: Host I/O cycle source standing in for the cycle decoder
// Assumes: One-cycle strobe per cycle, driven just after a rising edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/100ps
module host_io_model (
  input  wire        clk_i,
  output reg         io_valid_o,
  output reg         io_write_o,
  output reg  [15:0] io_addr_o,
  output reg  [7:0]  io_wdata_o
);
  initial begin
    io_valid_o = 1'b0;
    io_write_o = 1'b0;
    io_addr_o  = 16'hFFFF;
    io_wdata_o = 8'hFF;
  end
  task cyc(input w, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      io_valid_o <= 1'b1;
      io_write_o <= w;
      io_addr_o  <= a;
      io_wdata_o <= d;
      @(posedge clk_i);
      io_valid_o <= 1'b0;
      io_addr_o  <= ~a;
      io_wdata_o <= ~d;
      #1;
    end
  endtask
endmodule // host_io_model

// ===== dv/io_trap_monitor_apm_smi_tb.sv
// Purpose: Self-checking bench of the trap monitor and APM ports
// Assumes: ce_i held high; PM base far from the APM ports
// Notes:   Results are sampled 1 ns after the answering edge
`timescale 1ns/100ps
module io_trap_monitor_apm_smi_tb;
  reg         clk = 1'b0, resetn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  reg  [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00;
  reg         apm_dec = 1'b0, apm_irq = 1'b0;
  reg  [15:0] pm_base = 16'h4000;
  wire [7:0]  rdata, io_rdata, apm_cmd;
  wire [15:0] io_addr;
  wire [7:0]  io_wdata;
  wire [3:0]  hit;
  wire        rvalid, io_valid, io_write, claim, fwd, irq;
  integer     mismatches = 0, total_checks = 0;
  host_io_model host_io_model_i (.clk_i(clk), .io_valid_o(io_valid), .io_write_o(io_write),
    .io_addr_o(io_addr), .io_wdata_o(io_wdata));
  io_trap_monitor_apm_smi io_trap_monitor_apm_smi_i (.core_clk_i(clk), .resetn_i(resetn),
    .ce_i(1'b1), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .io_valid_i(io_valid),
    .io_write_i(io_write), .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_claim_o(claim), .power_mgmt_io_base_i(pm_base), .apm_port_decode_enable_i(apm_dec),
    .apm_command_irq_enable_i(apm_irq), .trap_hit_o(hit), .forward_lpc_o(fwd),
    .system_management_irq_o(irq), .apm_command_port_o(apm_cmd));
  initial forever #50 clk = ~clk;
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cw(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
    end
  endtask
  task cr(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk("cfg_rvalid", 1, {15'h0, rvalid});
      chk("cfg_rdata", e, {8'h00, rdata});
    end
  endtask
  task t_regs;
    begin
      cr(8'hC0, 8'h00);
      cw(8'hC0, 8'hFF);
      cr(8'hC0, 8'hF0);
      cw(8'hC6, 8'h34);
      cw(8'hC7, 8'h12);
      cr(8'hC7, 8'h12);
      cr(8'hC4, 8'h00);
      cw(8'hCD, 8'hA5);
      cr(8'hCD, 8'hA5);
      cr(8'hC2, 8'h00);
      $display("t_regs done");
    end
  endtask
  task t_trap;
    begin
      cw(8'hC4, 8'h30);
      cw(8'hC5, 8'h12);
      cw(8'hCC, 8'h03);
      host_io_model_i.cyc(1'b1, 16'h4040, 8'h10);
      host_io_model_i.cyc(1'b0, 16'h4040, 8'h00);
      chk("trap enable", 16'h10, {8'h00, io_rdata});
      host_io_model_i.cyc(1'b0, 16'h1233, 8'h00);
      chk("hit", 16'h1, {12'h0, hit});
      chk("irq fwd", 16'h3, {14'h0, irq, fwd});
      host_io_model_i.cyc(1'b0, 16'h1236, 8'h00);
      chk("hit", 16'h0, {12'h0, hit});
      cw(8'hC0, 8'h00);
      host_io_model_i.cyc(1'b0, 16'h1231, 8'h00);
      chk("irq fwd", 16'h2, {14'h0, irq, fwd});
      cw(8'hC0, 8'h10);
      host_io_model_i.cyc(1'b1, 16'h4040, 8'h00);
      host_io_model_i.cyc(1'b0, 16'h1230, 8'h00);
      chk("irq fwd", 16'h1, {14'h0, irq, fwd});
      cw(8'hCC, 8'hF3);
      host_io_model_i.cyc(1'b0, 16'h123F, 8'h00);
      chk("hit", 16'h2, {12'h0, hit});
      host_io_model_i.cyc(1'b0, 16'h4041, 8'h00);
      chk("trap status", 16'h30, {8'h00, io_rdata});
      host_io_model_i.cyc(1'b1, 16'h4041, 8'h10);
      host_io_model_i.cyc(1'b0, 16'h4041, 8'h00);
      chk("trap status clear", 16'h20, {8'h00, io_rdata});
      $display("t_trap done");
    end
  endtask
  task t_apm;
    begin
      host_io_model_i.cyc(1'b1, 16'h00B2, 8'h55);
      chk("claim", 16'h0, {15'h0, claim});
      @(posedge clk);
      apm_dec <= 1'b1;
      apm_irq <= 1'b1;
      host_io_model_i.cyc(1'b1, 16'h00B2, 8'h66);
      chk("claim irq", 16'h3, {14'h0, claim, irq});
      @(posedge clk);
      apm_irq <= 1'b0;
      #1;
      chk("apm_cmd", 16'h66, {8'h00, apm_cmd});
      host_io_model_i.cyc(1'b1, 16'h00B3, 8'hAA);
      host_io_model_i.cyc(1'b1, 16'h00B2, 8'h77);
      chk("irq", 16'h0, {15'h0, irq});
      host_io_model_i.cyc(1'b0, 16'h00B3, 8'h00);
      chk("scratch", 16'hAA, {8'h00, io_rdata});
      host_io_model_i.cyc(1'b0, 16'h00B2, 8'h00);
      chk("apm_cmd read", 16'h77, {8'h00, io_rdata});
      $display("t_apm done");
    end
  endtask
  task t_reset;
    begin
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      host_io_model_i.cyc(1'b0, 16'h00B3, 8'h00);
      chk("scratch after reset", 16'h00, {8'h00, io_rdata});
      cr(8'hC6, 8'h00);
      $display("t_reset done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_trap;
    t_apm;
    t_reset;
    complete_run;
  end
  initial begin
    #50000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule // io_trap_monitor_apm_smi_tb
bind io_trap_monitor_apm_smi io_trap_properties #(.MON_N(MON_N)) props_i (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cfg_rd_i(cfg_rd_i),
  .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
  .io_valid_i(io_valid_i), .io_write_i(io_write_i), .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i), .io_claim_o(io_claim_o), .power_mgmt_io_base_i(power_mgmt_io_base_i),
  .apm_port_decode_enable_i(apm_port_decode_enable_i), .trap_hit_o(trap_hit_o),
  .apm_command_irq_enable_i(apm_command_irq_enable_i), .forward_lpc_o(forward_lpc_o),
  .system_management_irq_o(system_management_irq_o), .apm_command_port_o(apm_command_port_o));
